// ---- hdl/fifo_watermark_status.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fifo_watermark_status
  import fifo_wm_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire bus_req_t bus,
  output logic [7:0] rd_data,
  // serial stream side
  input wire stream_req_t stream,
  output logic [7:0] tx_byte,
  // link events and sensors
  input wire link_evt_t link,
  input wire logic [7:0] temp_celsius,
  // status outputs
  output logic [2:0] link_fsm_state,
  output logic serial_filter_fast_force,
  output logic card_cipher_active,
  output logic overheat_error,
  output logic near_full_alert,
  output logic near_empty_alert
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_data, rd_port, wr_level, wr_link, wr_thr, wr_frame, wr_cfg, wr_txw, wr_rxw;
  assign wr_data = bus.wr && (bus.addr == DATA_PORT_ADDR);
  assign rd_port = bus.rd && (bus.addr == DATA_PORT_ADDR);
  assign wr_level = bus.wr && (bus.addr == FILL_LEVEL_ADDR);
  assign wr_link = bus.wr && (bus.addr == LINK_STATUS_ADDR);
  assign wr_thr = bus.wr && (bus.addr == THRESHOLD_ADDR);
  assign wr_frame = bus.wr && (bus.addr == FRAME_CTRL_ADDR);
  assign wr_cfg = bus.wr && (bus.addr == WAIT_CFG_ADDR);
  assign wr_txw = bus.wr && (bus.addr == TX_WAIT_TIME_ADDR);
  assign wr_rxw = bus.wr && (bus.addr == RX_WAIT_TIME_ADDR);

  // ----------------------------------------
  // buffer state
  // ----------------------------------------
  logic [7:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [CNT_W-1:0] count_ff, nxt_count;
  logic overrun_ff, nxt_overrun;
  logic push, pop, host_pop, strm_pop, purge, drop;
  logic [7:0] push_byte;
  logic full, empty;

  assign full = (count_ff == DEPTH_CNT);
  assign empty = (count_ff == FILL_RST);
  assign purge = wr_level && bus.wdata[PURGE_BIT];
  // host port wins a tie; the stream byte of that cycle is lost as overrun
  assign push_byte = wr_data ? bus.wdata : stream.byte_in;
  assign drop = (wr_data && stream.push) || ((wr_data || stream.push) && full && !pop);
  assign push = (wr_data || stream.push) && (!full || pop) && !purge;
  assign host_pop = rd_port && !empty && !purge;
  assign strm_pop = stream.pop && !rd_port && !empty && !purge;
  assign pop = host_pop || strm_pop;

  // pointers, count and overrun flag
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    nxt_overrun = overrun_ff;
    if (purge) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_count = FILL_RST;
      nxt_overrun = 1'b0;
    end else begin
      if (push) begin
        nxt_wr_ptr = wr_ptr_ff + 6'h01;
      end
      if (pop) begin
        nxt_rd_ptr = rd_ptr_ff + 6'h01;
      end
      if (push && !pop) begin
        nxt_count = count_ff + 7'h01;
      end else if (pop && !push) begin
        nxt_count = count_ff - 7'h01;
      end
    end
    // a fresh overrun beats a purge in the same cycle
    if (drop) begin
      nxt_overrun = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= FILL_RST;
      overrun_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      overrun_ff <= nxt_overrun;
    end
  end

  // storage has no reset, so the port reads undefined until written
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_ff] <= push_byte;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [5:0] thr_ff, nxt_thr;
  logic fast_ff, nxt_fast, cipher_ff, nxt_cipher, temp_err_ff, nxt_temp_err;
  logic txf_ff, nxt_txf, rxf_ff, nxt_rxf;
  logic [7:0] txw_ff, nxt_txw, rxw_ff, nxt_rxw;
  logic temp_ok;

  assign temp_ok = (temp_celsius < TEMP_LIMIT_C);

  always_comb begin
    nxt_thr = thr_ff;
    nxt_fast = fast_ff;
    nxt_cipher = cipher_ff;
    nxt_temp_err = temp_err_ff;
    nxt_txf = txf_ff;
    nxt_rxf = rxf_ff;
    nxt_txw = txw_ff;
    nxt_rxw = rxw_ff;
    if (wr_thr) begin
      nxt_thr = bus.wdata[5:0];
    end
    if (wr_link) begin
      nxt_fast = bus.wdata[FAST_FORCE_BIT];
      if (!bus.wdata[CIPHER_BIT]) begin
        nxt_cipher = 1'b0;
      end
      if (bus.wdata[OVERHEAT_CLR_BIT] && temp_ok) begin
        nxt_temp_err = 1'b0;
      end
    end
    // hardware sets win over the software clears
    if (link.auth_ok) begin
      nxt_cipher = 1'b1;
    end
    if (!temp_ok) begin
      nxt_temp_err = 1'b1;
    end
    if (wr_cfg) begin
      nxt_txf = bus.wdata[TX_FIELD_BIT];
      nxt_rxf = bus.wdata[RX_FIELD_BIT];
    end
    if (wr_txw) begin
      nxt_txw = bus.wdata;
    end
    if (wr_rxw) begin
      nxt_rxw = bus.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      thr_ff <= THRESHOLD_RST;
      fast_ff <= 1'b0;
      cipher_ff <= 1'b0;
      temp_err_ff <= 1'b0;
      txf_ff <= 1'b0;
      rxf_ff <= 1'b0;
      txw_ff <= WAIT_TIME_RST;
      rxw_ff <= WAIT_TIME_RST;
    end else begin
      thr_ff <= nxt_thr;
      fast_ff <= nxt_fast;
      cipher_ff <= nxt_cipher;
      temp_err_ff <= nxt_temp_err;
      txf_ff <= nxt_txf;
      rxf_ff <= nxt_rxf;
      txw_ff <= nxt_txw;
      rxw_ff <= nxt_rxw;
    end
  end

  // ----------------------------------------
  // link state machine
  // ----------------------------------------
  link_state_t state_ff, nxt_state;
  logic [3:0] div_ff, nxt_div;
  logic [7:0] wait_ff, nxt_wait;
  logic launch, tick, tx_go, rx_go;
  logic [2:0] nxt_code;

  // launch only counts while waiting for it inside a transceive
  assign launch = wr_frame && bus.wdata[LAUNCH_BIT] && link.transceive_active;
  assign tick = (div_ff == WAIT_TICK_LAST);
  assign tx_go = (wait_ff >= txw_ff) && (!txf_ff || link.rf_field);
  assign rx_go = (wait_ff >= rxw_ff) && (!rxf_ff || link.rf_field);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE: if (link.transceive_active) nxt_state = S_WAIT_LAUNCH;
      S_WAIT_LAUNCH: if (launch) nxt_state = S_TX_WAIT;
      S_TX_WAIT: if (tx_go) nxt_state = S_TRANSMIT;
      S_TRANSMIT: if (link.tx_done) nxt_state = S_RX_WAIT;
      S_RX_WAIT: if (rx_go) nxt_state = S_WAIT_DATA;
      S_WAIT_DATA: if (link.rx_start) nxt_state = S_RECEIVE;
      S_RECEIVE: if (link.rx_done) nxt_state = S_WAIT_LAUNCH;
    endcase
    if (!link.transceive_active) begin
      nxt_state = S_IDLE;
    end
  end

  // wait time counts slow ticks from entry into a wait state
  always_comb begin
    nxt_div = tick ? 4'h0 : div_ff + 4'h1;
    nxt_wait = wait_ff;
    if (nxt_state != state_ff) begin
      nxt_wait = 8'h00;
      nxt_div = 4'h0;
    end else if (tick && wait_ff != 8'hff) begin
      nxt_wait = wait_ff + 8'h01;
    end
  end

  always_comb begin
    unique case (nxt_state)
      S_IDLE: nxt_code = CODE_IDLE;
      S_WAIT_LAUNCH: nxt_code = CODE_WAIT_LAUNCH;
      S_TX_WAIT: nxt_code = CODE_TX_WAIT;
      S_TRANSMIT: nxt_code = CODE_TRANSMIT;
      S_RX_WAIT: nxt_code = CODE_RX_WAIT;
      S_WAIT_DATA: nxt_code = CODE_WAIT_DATA;
      S_RECEIVE: nxt_code = CODE_RECEIVE;
      default: nxt_code = CODE_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= S_IDLE;
      div_ff <= 4'h0;
      wait_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      div_ff <= nxt_div;
      wait_ff <= nxt_wait;
    end
  end

  // ----------------------------------------
  // read mux and registered outputs
  // ----------------------------------------
  logic [7:0] nxt_rd_data, rd_data_ff, tx_byte_ff, nxt_tx_byte;
  logic [2:0] code_ff;
  logic nf_ff, ne_ff, nxt_nf, nxt_ne;

  // alerts follow the count as it will stand after this edge
  assign nxt_nf = ((DEPTH_CNT - nxt_count) <= {1'b0, nxt_thr});
  assign nxt_ne = (nxt_count <= {1'b0, nxt_thr});
  assign nxt_tx_byte = strm_pop ? mem[rd_ptr_ff] : tx_byte_ff;

  // unmapped addresses and write-only bits read as zero
  always_comb begin
    nxt_rd_data = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        DATA_PORT_ADDR: nxt_rd_data = mem[rd_ptr_ff];
        FILL_LEVEL_ADDR: nxt_rd_data = {1'b0, count_ff};
        THRESHOLD_ADDR: nxt_rd_data = {2'b00, thr_ff};
        LINK_STATUS_ADDR: nxt_rd_data = {1'b0, fast_ff, 2'b00, cipher_ff, code_ff};
        PRIMARY_STATUS_ADDR: nxt_rd_data = {6'h00, nf_ff, ne_ff};
        ERROR_FLAGS_ADDR: nxt_rd_data = {1'b0, temp_err_ff, 1'b0, overrun_ff, 4'h0};
        WAIT_CFG_ADDR: nxt_rd_data = {6'h00, rxf_ff, txf_ff};
        TX_WAIT_TIME_ADDR: nxt_rd_data = txw_ff;
        RX_WAIT_TIME_ADDR: nxt_rd_data = rxw_ff;
        default: nxt_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data_ff <= 8'h00;
      tx_byte_ff <= 8'h00;
      code_ff <= CODE_IDLE;
      nf_ff <= 1'b0;
      ne_ff <= 1'b1;
    end else begin
      rd_data_ff <= nxt_rd_data;
      tx_byte_ff <= nxt_tx_byte;
      code_ff <= nxt_code;
      nf_ff <= nxt_nf;
      ne_ff <= nxt_ne;
    end
  end

  assign rd_data = rd_data_ff;
  assign tx_byte = tx_byte_ff;
  assign link_fsm_state = code_ff;
  assign serial_filter_fast_force = fast_ff;
  assign card_cipher_active = cipher_ff;
  assign overheat_error = temp_err_ff;
  assign near_full_alert = nf_ff;
  assign near_empty_alert = ne_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_purge_write;
    bus.wr && bus.addr == FILL_LEVEL_ADDR && bus.wdata[PURGE_BIT];
  endsequence

  a_purge_empties: assert property (s_purge_write |=> count_ff == 7'h00 && !overrun_ff
    || $past(drop)) else $error("purge did not empty buffer");
  a_count_push: assert property (push && !pop |=> count_ff == $past(count_ff) + 7'h01)
    else $error("push did not raise count");
  a_count_bound: assert property (count_ff <= DEPTH_CNT)
    else $error("count above depth");
  a_full_drop: assert property (full && wr_data && !pop |=> overrun_ff && count_ff == DEPTH_CNT)
    else $error("full write not dropped");
  a_alert_match: assert property (near_empty_alert == (count_ff <= {1'b0, thr_ff})
    && near_full_alert == ((DEPTH_CNT - count_ff) <= {1'b0, thr_ff}))
    else $error("alert mismatch");
  a_cipher_set: assert property ($rose(card_cipher_active) |-> $past(link.auth_ok))
    else $error("cipher set without authentication");
  a_overheat_keep: assert property (wr_link && bus.wdata[OVERHEAT_CLR_BIT] && !temp_ok
    |=> overheat_error) else $error("overheat cleared while hot");
  a_tx_wait_min: assert property (state_ff == S_TX_WAIT && nxt_state == S_TRANSMIT
    |-> wait_ff >= txw_ff) else $error("transmit wait too short");
  a_rx_wait_min: assert property (state_ff == S_RX_WAIT && nxt_state == S_WAIT_DATA
    |-> wait_ff >= rxw_ff) else $error("receive wait too short");
  a_launch_gate: assert property (state_ff == S_WAIT_LAUNCH && !launch
    |=> state_ff != S_TX_WAIT) else $error("transmit without launch");
  a_read_latency: assert property (bus.rd && bus.addr == THRESHOLD_ADDR
    |=> rd_data == {2'b00, $past(thr_ff)}) else $error("threshold read wrong");
  a_count_pop: assert property (pop && !push |=> count_ff == $past(count_ff) - 7'h01)
    else $error("pop did not lower count");
  a_cipher_clear: assert property (wr_link && !bus.wdata[CIPHER_BIT] && !link.auth_ok
    |=> !card_cipher_active) else $error("cipher clear refused");
  a_overrun_purge: assert property (purge && !drop |=> !overrun_ff)
    else $error("purge left overrun set");
  a_fast_follow: assert property (wr_link
    |=> serial_filter_fast_force == $past(bus.wdata[FAST_FORCE_BIT])) else $error("fast force lost");

endmodule
`default_nettype wire

// ---- hdl/fifo_wm_pkg.sv ----
package fifo_wm_pkg;
  // ----------------------------------------
  // buffer geometry
  // ----------------------------------------
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int DEPTH = 64;
  localparam logic [6:0] DEPTH_CNT = 7'h40;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ERROR_FLAGS_ADDR = 8'h06;
  localparam logic [7:0] PRIMARY_STATUS_ADDR = 8'h07;
  localparam logic [7:0] LINK_STATUS_ADDR = 8'h08;
  localparam logic [7:0] DATA_PORT_ADDR = 8'h09;
  localparam logic [7:0] FILL_LEVEL_ADDR = 8'h0a;
  localparam logic [7:0] THRESHOLD_ADDR = 8'h0b;
  localparam logic [7:0] FRAME_CTRL_ADDR = 8'h0d;
  localparam logic [7:0] WAIT_CFG_ADDR = 8'h20;
  localparam logic [7:0] TX_WAIT_TIME_ADDR = 8'h21;
  localparam logic [7:0] RX_WAIT_TIME_ADDR = 8'h22;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int OVERHEAT_CLR_BIT = 7;
  localparam int FAST_FORCE_BIT = 6;
  localparam int CIPHER_BIT = 3;
  localparam int PURGE_BIT = 7;
  localparam int LAUNCH_BIT = 7;
  localparam int OVERRUN_BIT = 4;
  localparam int TEMP_ERR_BIT = 6;
  localparam int NEAR_FULL_BIT = 1;
  localparam int NEAR_EMPTY_BIT = 0;
  localparam int TX_FIELD_BIT = 0;
  localparam int RX_FIELD_BIT = 1;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [5:0] THRESHOLD_RST = 6'h08;
  localparam logic [6:0] FILL_RST = 7'h00;
  localparam logic [7:0] WAIT_TIME_RST = 8'h00;
  localparam logic [7:0] TEMP_LIMIT_C = 8'h7d;
  localparam logic [3:0] WAIT_TICK_LAST = 4'hf;
  // ----------------------------------------
  // link state codes
  // ----------------------------------------
  localparam logic [2:0] CODE_IDLE = 3'h0;
  localparam logic [2:0] CODE_WAIT_LAUNCH = 3'h1;
  localparam logic [2:0] CODE_TX_WAIT = 3'h2;
  localparam logic [2:0] CODE_TRANSMIT = 3'h3;
  localparam logic [2:0] CODE_RX_WAIT = 3'h4;
  localparam logic [2:0] CODE_WAIT_DATA = 3'h5;
  localparam logic [2:0] CODE_RECEIVE = 3'h6;
  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_LAUNCH, S_TX_WAIT, S_TRANSMIT, S_RX_WAIT, S_WAIT_DATA, S_RECEIVE
  } link_state_t;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] byte_in;
  } stream_req_t;
  typedef struct packed {
    logic transceive_active;
    logic auth_ok;
    logic rf_field;
    logic tx_done;
    logic rx_start;
    logic rx_done;
  } link_evt_t;
endpackage

// ---- sim/fifo_watermark_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_watermark_status_tb;
  import fifo_wm_pkg::*;
  typedef struct {
    string name;
    logic [7:0] exp;
    logic [7:0] mask;
  } note_t;
  logic clock;
  logic reset;
  bus_req_t bus;
  stream_req_t stream;
  link_evt_t link;
  logic [7:0] temp_celsius;
  logic [7:0] rd_data;
  logic [7:0] tx_byte;
  logic [2:0] link_fsm_state;
  logic serial_filter_fast_force;
  logic card_cipher_active;
  logic overheat_error;
  logic near_full_alert;
  logic near_empty_alert;
  logic rd_q;
  logic pop_q;
  int n_mismatch;
  int checked;
  note_t rd_notes[$];
  note_t tx_notes[$];
  logic [7:0] model[$];

  fifo_watermark_status dut (
    .clock(clock), .reset(reset), .bus(bus), .rd_data(rd_data), .stream(stream),
    .tx_byte(tx_byte), .link(link), .temp_celsius(temp_celsius),
    .link_fsm_state(link_fsm_state), .serial_filter_fast_force(serial_filter_fast_force),
    .card_cipher_active(card_cipher_active), .overheat_error(overheat_error),
    .near_full_alert(near_full_alert), .near_empty_alert(near_empty_alert)
  );

  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // a hung wait must still reach the verdict
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk1(input string name, input logic seen, input logic exp);
    check(name, {7'h00, seen}, {7'h00, exp});
  endtask

  // ----------------------------------------
  // result watcher: oldest note per answer
  // ----------------------------------------
  always @(posedge clock) begin
    rd_q <= bus.rd;
    pop_q <= stream.pop;
  end

  // negedge sampling keeps clear of the edge that launches the answer
  always @(negedge clock) begin
    note_t n;
    if (rd_q === 1'b1 && rd_notes.size() > 0) begin
      n = rd_notes.pop_front();
      check(n.name, rd_data & n.mask, n.exp & n.mask);
    end
    if (pop_q === 1'b1 && tx_notes.size() > 0) begin
      n = tx_notes.pop_front();
      check(n.name, tx_byte & n.mask, n.exp & n.mask);
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    if (a == DATA_PORT_ADDR && model.size() < DEPTH) model.push_back(d);
    if (a == FILL_LEVEL_ADDR && d[7]) model.delete();
    // one-cycle strobe: a held write strobe would land a second time
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge clock);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    rd_notes.push_back('{name, e, m});
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic push_s(input logic [7:0] b);
    @(posedge clock);
    stream <= '{push: 1'b1, pop: 1'b0, byte_in: b};
    if (model.size() < DEPTH) model.push_back(b);
    // drop the push after one edge, else the next task pushes it again
    @(posedge clock);
    stream <= '0;
  endtask

  // empty pops leave a stale byte, so the note masks it out
  task automatic pop_any(input logic host);
    logic [7:0] e;
    logic [7:0] m;
    e = 8'h00;
    m = 8'h00;
    if (model.size() > 0) begin
      e = model.pop_front();
      m = 8'hff;
    end
    if (host) begin
      rd("data_port", DATA_PORT_ADDR, e, m);
    end else begin
      @(posedge clock);
      stream <= '{push: 1'b0, pop: 1'b1, byte_in: 8'h00};
      tx_notes.push_back('{"tx_byte", e, m});
      @(posedge clock);
      stream <= '0;
    end
  endtask

  task automatic idle(input int n);
    @(posedge clock);
    bus <= '0;
    stream <= '0;
    repeat (n) @(posedge clock);
  endtask

  task automatic evt(input logic [3:0] p);
    @(posedge clock);
    {link.auth_ok, link.tx_done, link.rx_start, link.rx_done} <= p;
  endtask

  task automatic alerts(input int thr);
    #1;
    chk1("near_full", near_full_alert, (DEPTH - model.size()) <= thr);
    chk1("near_empty", near_empty_alert, model.size() <= thr);
  endtask

  task automatic wait_state(input logic [2:0] code, input int bound);
    int i;
    #1;
    for (i = 0; i < bound && link_fsm_state !== code; i++) begin
      @(posedge clock);
      #1;
    end
    check("link_fsm_state", {5'h00, link_fsm_state}, {5'h00, code});
    if (link_fsm_state !== code) finish_test();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int i;
    bus = '0;
    stream = '0;
    link = '0;
    temp_celsius = 8'd25;
    reset = 1'b1;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'h5c0a1292));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk1("near_empty", near_empty_alert, 1'b1);
    chk1("near_full", near_full_alert, 1'b0);
    rd("fill_level", FILL_LEVEL_ADDR, FILL_RST, 8'hff);
    rd("threshold", THRESHOLD_ADDR, 8'h08, 8'hff);
    rd("link_status", LINK_STATUS_ADDR, 8'h00, 8'hff);
    rd("unmapped", 8'h3f, 8'h00, 8'hff);
    wr(THRESHOLD_ADDR, 8'hff);
    rd("threshold", THRESHOLD_ADDR, 8'h3f, 8'hff);
    wr(THRESHOLD_ADDR, 8'h04);
    // fill from both sides, count and alerts at every level
    for (i = 0; i < DEPTH; i++) begin
      if (i[0]) wr(DATA_PORT_ADDR, 8'($urandom));
      else push_s(8'($urandom));
      rd("fill_level", FILL_LEVEL_ADDR, 8'(model.size()), 8'hff);
      idle(2);
      alerts(4);
    end
    wr(DATA_PORT_ADDR, 8'ha5);
    push_s(8'h5a);
    rd("fill_level", FILL_LEVEL_ADDR, DEPTH_CNT, 8'hff);
    rd("overrun", ERROR_FLAGS_ADDR, 8'h10, 8'h10);
    // drain in mixed order, then read past empty
    for (i = 0; i < DEPTH; i++) begin
      pop_any(1'($urandom));
      idle(2);
      alerts(4);
    end
    pop_any(1'b1);
    pop_any(1'b0);
    rd("fill_level", FILL_LEVEL_ADDR, 8'h00, 8'hff);
    // purge with bytes pending and overrun still set
    wr(DATA_PORT_ADDR, 8'h11);
    wr(DATA_PORT_ADDR, 8'h22);
    wr(FILL_LEVEL_ADDR, 8'h80);
    rd("fill_level", FILL_LEVEL_ADDR, 8'h00, 8'hff);
    rd("overrun", ERROR_FLAGS_ADDR, 8'h00, 8'h10);
    wr(DATA_PORT_ADDR, 8'h33);
    pop_any(1'b1);
    // fast-force, reserved bits, cipher flag
    wr(LINK_STATUS_ADDR, 8'h78);
    rd("link_status", LINK_STATUS_ADDR, 8'h40, 8'hff);
    idle(1);
    chk1("fast_force", serial_filter_fast_force, 1'b1);
    evt(4'h8);
    evt(4'h0);
    idle(1);
    chk1("cipher", card_cipher_active, 1'b1);
    wr(LINK_STATUS_ADDR, 8'h08);
    rd("link_status", LINK_STATUS_ADDR, 8'h08, 8'hff);
    wr(LINK_STATUS_ADDR, 8'h00);
    idle(1);
    chk1("cipher", card_cipher_active, 1'b0);
    chk1("fast_force", serial_filter_fast_force, 1'b0);
    // overheat: clear refused at the limit, accepted below it
    temp_celsius <= 8'd125;
    wr(LINK_STATUS_ADDR, 8'h80);
    idle(2);
    chk1("overheat", overheat_error, 1'b1);
    temp_celsius <= 8'd124;
    idle(2);
    chk1("overheat", overheat_error, 1'b1);
    wr(LINK_STATUS_ADDR, 8'h80);
    rd("link_status", LINK_STATUS_ADDR, 8'h00, 8'h80);
    idle(1);
    chk1("overheat", overheat_error, 1'b0);
    // link machine walk
    wr(FRAME_CTRL_ADDR, 8'h80);
    idle(3);
    wait_state(CODE_IDLE, 1);
    idle(0);
    link.transceive_active <= 1'b1;
    wait_state(CODE_WAIT_LAUNCH, 4);
    wr(TX_WAIT_TIME_ADDR, 8'h02);
    wr(RX_WAIT_TIME_ADDR, 8'h02);
    wr(WAIT_CFG_ADDR, 8'h01);
    wr(FRAME_CTRL_ADDR, 8'h80);
    idle(1);
    wait_state(CODE_TX_WAIT, 4);
    idle(60);
    wait_state(CODE_TX_WAIT, 1);
    idle(0);
    link.rf_field <= 1'b1;
    wait_state(CODE_TRANSMIT, 6);
    evt(4'h4);
    evt(4'h0);
    wait_state(CODE_RX_WAIT, 4);
    idle(20);
    wait_state(CODE_RX_WAIT, 1);
    wait_state(CODE_WAIT_DATA, 60);
    evt(4'h2);
    evt(4'h0);
    wait_state(CODE_RECEIVE, 4);
    evt(4'h1);
    evt(4'h0);
    wait_state(CODE_WAIT_LAUNCH, 4);
    rd("link_status", LINK_STATUS_ADDR, 8'h01, 8'h07);
    idle(0);
    link.transceive_active <= 1'b0;
    wait_state(CODE_IDLE, 4);
    idle(3);
    finish_test();
  end
endmodule
`default_nettype wire
